//--- hdl/aec_axis_cfg.sv
// Axis activation, alarm power control and functional encoder logic
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - Inactive axis refuses power-on and stays inhibited
// R2 - Activation cleared when board address differs from stored one
// R3 - Activation written and read through the control register
// R4 - Any alarm switches motor power off
// R5 - Power-on request refused while any alarm persists
// R6 - Alarms: overcurrent, external alarm, follow error in closed loop
// R7 - Overtemperature warning reported only, never blocks power-on
// R8 - Optional restore of stored power state after power cycle
// R9 - Alarm at power-up skips the restore power-on
// R10 - Host programs axis turn as whole electrical periods (pole pairs)
// R11 - Three inputs: rear incremental, front incremental, rear absolute serial
// R12 - Each role uses the physical input chosen by configuration
// R13 - Final position encoder may feed position regulation
// R14 - Rotor encoder feeds torque path and may feed regulation
// R15 - Safety encoder versus axis position beyond limit trips alarm
// R16 - Role without input disables its function
// R17 - Axis step is a configured electrical phase increment
// R18 - Positions reported as signed 32-bit counts
// R19 - Positions held internally as 64-bit electrical fixed point
// R20 - Step size from step count over axis turns
// R21 - Each encoder resolution configured independently over axis turns
// R22 - Raw readback in encoder units, converted readback in axis steps
// R23 - Configuration kept in non-volatile store and read back
// R24 - Measured position: final encoder, else rotor, else nominal
// R25 - Conversions round half away from zero and flag overflow
module aec_axis_cfg (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Board pins, asynchronous
  input wire logic [7:0] slot_addr_pin,
  input wire logic overcurrent_pin,
  input wire logic ext_alarm_pin,
  input wire logic overtemp_pin,
  // Motion logic, same clock
  input wire logic follow_err,
  input wire logic [63:0] nominal_pos,
  input wire aec_pkg::aec_cnt_t enc_count,
  // Non-volatile store
  input wire logic nv_valid,
  input wire aec_pkg::aec_cfg_s nv_cfg,
  output logic nv_wr,
  output aec_pkg::aec_cfg_s nv_data,
  // Axis outputs
  output logic motor_power,
  output logic axis_inhibit,
  output logic alarm,
  output logic warning,
  output logic fb_valid,
  output logic [63:0] fb_pos,
  output logic rotor_valid,
  output logic [63:0] rotor_pos
);

  function automatic logic [63:0] to_elec(input logic [31:0] cnt, input logic [63:0] size);
    logic signed [63:0] c;
    c = {{32{cnt[31]}}, cnt};
    to_elec = 64'(c * $signed(size));
  endfunction : to_elec

  function automatic logic [63:0] role_elec(input aec_pkg::aec_src_e r, input aec_pkg::aec_cnt_t cnt,
                                             input logic [3:0][63:0] sz);
    logic [1:0] i;
    i = 2'(r) - 2'h1;
    role_elec = (r == aec_pkg::SRC_NONE) ? 64'h0 : to_elec(cnt[i], sz[2'(i + 2'h1)]);
  endfunction : role_elec

  function automatic logic [63:0] abs64(input logic [63:0] v);
    abs64 = v[63] ? 64'(-v) : v;
  endfunction : abs64

  // Encoder register decode: hit, encoder index, turns word
  function automatic logic [3:0] enc_slot(input logic [7:0] a);
    logic hit;
    hit = (a >= aec_pkg::OFS_ENC_LO) && (a <= aec_pkg::OFS_ENC_HI);
    enc_slot = {hit, 2'(a[5:3] - 3'h2), a[2]};
  endfunction : enc_slot

  // Cut to 32 bits with saturation
  function automatic logic [32:0] sat32(input logic [63:0] q, input logic neg, input logic den0);
    logic [63:0] lim;
    lim = neg ? {32'h0, aec_pkg::SAT_NEG} : {32'h0, aec_pkg::SAT_POS};
    if (den0 || q > lim)
      sat32 = {1'b1, neg ? aec_pkg::SAT_NEG : aec_pkg::SAT_POS};
    else
      sat32 = {1'b0, neg ? 32'(-q[31:0]) : q[31:0]};
  endfunction : sat32

  aec_pkg::aec_cfg_s cfg_r;
  aec_pkg::aec_cfg_s nv_data_r;
  aec_pkg::aec_boot_e boot_r;
  aec_pkg::aec_div_e dv_r;
  aec_pkg::aec_stat_s stat;
  logic [10:0] pin_q1_r, pin_q2_r;
  logic [7:0] addr_s;
  logic oc_s, ext_s, ot_s;
  logic wr_en_r, nv_wr_r, saved_pwr_r, restored_r, skip_r, refused_r, trip_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r, rd_val;
  logic hready_r, inhibit_r, alarm_r, warn_r, fb_valid_r, rot_valid_r;
  logic [63:0] fb_pos_r, rot_pos_r, meas_el_r, pick_el_r, saf_el, lim_el;
  logic [1:0] pick_r;
  logic [3:0][63:0] size_r;
  logic [2:0][31:0] conv_r;
  logic [2:0] ovf_r;
  logic [2:0] job_r;
  logic [6:0] cnt_r;
  logic [63:0] num_r, den_r, rem_r, dnum, dden, dval;
  logic [64:0] trial;
  logic neg_r, dneg, alarm_any, moved, wr_ok, pwr_req, pwr_ok;
  logic [3:0] wslot, rslot;
  logic [32:0] sat;

  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pin_q1_r <= '0;
      pin_q2_r <= '0;
    end
    else
    begin
      pin_q1_r <= {slot_addr_pin, overcurrent_pin, ext_alarm_pin, overtemp_pin};
      pin_q2_r <= pin_q1_r;
    end
  assign {addr_s, oc_s, ext_s, ot_s} = pin_q2_r;

  // Follow error counts only while regulation is closed
  assign alarm_any = oc_s | ext_s | (follow_err & fb_valid_r) | trip_r; // [R6] [R15]
  assign moved = (addr_s != cfg_r.board_addr);
  assign wr_ok = wr_en_r && (boot_r == aec_pkg::BT_RUN);
  assign pwr_req = wr_ok && (addr_r == aec_pkg::OFS_CTRL) && hwdata[aec_pkg::CTRL_PWR];
  // Warning deliberately absent from the grant
  assign pwr_ok = cfg_r.active && hwdata[aec_pkg::CTRL_ACT] && !alarm_any && !moved; // [R1] [R5] [R7]
  assign wslot = enc_slot(addr_r);

  // Bus address phase; zero wait states, read data registered here
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_en_r <= 1'b0;
      addr_r <= '0;
      hrdata_r <= '0;
      hready_r <= 1'b1;
    end
    else
    begin
      hready_r <= 1'b1;
      wr_en_r <= hsel && htrans[1] && hready && hwrite && (hsize == aec_pkg::HSIZE_WORD);
      if (hsel && htrans[1] && hready)
      begin
        addr_r <= haddr[7:0];
        if (!hwrite)
          hrdata_r <= rd_val;
      end
    end

  // Boot sequence
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      boot_r <= aec_pkg::BT_LOAD;
    else
      unique case (boot_r)
        aec_pkg::BT_LOAD: boot_r <= aec_pkg::BT_SYNC;
        aec_pkg::BT_SYNC: boot_r <= aec_pkg::BT_CHECK;
        aec_pkg::BT_CHECK: boot_r <= aec_pkg::BT_RUN;
        aec_pkg::BT_RUN: boot_r <= aec_pkg::BT_RUN;
      endcase

  // Configuration and motor power
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cfg_r <= '0;
      saved_pwr_r <= 1'b0;
      restored_r <= 1'b0;
      skip_r <= 1'b0;
    end
    else
      unique case (boot_r)
        aec_pkg::BT_LOAD:
        begin
          cfg_r <= nv_valid ? nv_cfg : '0; // [R23]
          cfg_r.power <= 1'b0;
          saved_pwr_r <= nv_valid && nv_cfg.power;
        end
        aec_pkg::BT_SYNC:
        begin
        end
        aec_pkg::BT_CHECK:
        begin
          if (moved)
          begin
            cfg_r.active <= 1'b0; // [R2]
            cfg_r.board_addr <= addr_s;
          end
          cfg_r.power <= cfg_r.restore && saved_pwr_r && cfg_r.active && !moved && !alarm_any; // [R8] [R9]
          restored_r <= cfg_r.restore && saved_pwr_r && cfg_r.active && !moved && !alarm_any;
          skip_r <= cfg_r.restore && saved_pwr_r && alarm_any; // [R9]
        end
        aec_pkg::BT_RUN:
        begin
          if (wr_ok)
          begin
            if (addr_r == aec_pkg::OFS_CTRL)
            begin
              cfg_r.active <= hwdata[aec_pkg::CTRL_ACT]; // [R3]
              cfg_r.restore <= hwdata[aec_pkg::CTRL_RST];
              cfg_r.fb_sel <= aec_pkg::aec_fb_e'(hwdata[aec_pkg::CTRL_FB +: 2]);
              cfg_r.power <= pwr_req && pwr_ok; // [R1] [R5]
            end
            if (addr_r == aec_pkg::OFS_ROLE)
            begin
              cfg_r.final_position_encoder_role <= aec_pkg::aec_src_e'(hwdata[aec_pkg::ROLE_FIN +: 2]); // [R12]
              cfg_r.rotor_encoder_role <= aec_pkg::aec_src_e'(hwdata[aec_pkg::ROLE_ROT +: 2]);
              cfg_r.safety_encoder_role <= aec_pkg::aec_src_e'(hwdata[aec_pkg::ROLE_SAF +: 2]);
            end
            if (addr_r == aec_pkg::OFS_STEPS)
              cfg_r.axis_steps <= hwdata; // [R20]
            if (addr_r == aec_pkg::OFS_TURNS)
            begin
              cfg_r.axis_turns <= hwdata[aec_pkg::TURNS_PP-1:0];
              cfg_r.pole_pairs <= hwdata[31:aec_pkg::TURNS_PP]; // [R10]
            end
            if (addr_r == aec_pkg::OFS_SAFE)
              cfg_r.safe_limit <= hwdata;
            if (wslot[3] && !wslot[0])
              cfg_r.enc_steps[wslot[2:1]] <= hwdata; // [R21]
            if (wslot[3] && wslot[0])
              cfg_r.enc_turns[wslot[2:1]] <= hwdata[15:0];
          end
          if (moved)
          begin
            cfg_r.active <= 1'b0; // [R2]
            cfg_r.board_addr <= addr_s;
          end
          // Alarm and loss of activation override any grant
          if (alarm_any || moved || !cfg_r.active)
            cfg_r.power <= 1'b0; // [R1] [R4]
        end
      endcase

  // Refused power request; a new refusal wins over the clear
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      refused_r <= 1'b0;
    else if (pwr_req && !pwr_ok)
      refused_r <= 1'b1; // [R5]
    else if (wr_ok && addr_r == aec_pkg::OFS_STAT && hwdata[aec_pkg::STAT_REFUSED])
      refused_r <= 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      pick_r <= '0;
    else if (wr_ok && addr_r == aec_pkg::OFS_PICK)
      pick_r <= hwdata[1:0];

  // Non-volatile mirror: one pulse per change
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      nv_data_r <= '0;
      nv_wr_r <= 1'b0;
    end
    else
    begin
      nv_data_r <= cfg_r;
      nv_wr_r <= (boot_r == aec_pkg::BT_RUN) && (cfg_r != nv_data_r); // [R23]
    end

  // Encoder roles, positions and safety check
  assign saf_el = role_elec(cfg_r.safety_encoder_role, enc_count, size_r);
  assign lim_el = 64'({32'h0, cfg_r.safe_limit} * size_r[0]);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      meas_el_r <= '0;
      pick_el_r <= '0;
      fb_pos_r <= '0;
      fb_valid_r <= 1'b0;
      rot_pos_r <= '0;
      rot_valid_r <= 1'b0;
      trip_r <= 1'b0;
    end
    else
    begin
      if (cfg_r.final_position_encoder_role != aec_pkg::SRC_NONE)
        meas_el_r <= role_elec(cfg_r.final_position_encoder_role, enc_count, size_r); // [R24]
      else if (cfg_r.rotor_encoder_role != aec_pkg::SRC_NONE)
        meas_el_r <= role_elec(cfg_r.rotor_encoder_role, enc_count, size_r);
      else
        meas_el_r <= nominal_pos;
      pick_el_r <= (pick_r == 2'h3) ? 64'h0 : to_elec(enc_count[pick_r], size_r[2'(pick_r + 2'h1)]); // [R11]
      rot_pos_r <= role_elec(cfg_r.rotor_encoder_role, enc_count, size_r); // [R14]
      rot_valid_r <= cfg_r.rotor_encoder_role != aec_pkg::SRC_NONE; // [R16]
      if (cfg_r.fb_sel == aec_pkg::FB_FINAL)
      begin
        fb_pos_r <= role_elec(cfg_r.final_position_encoder_role, enc_count, size_r); // [R13]
        fb_valid_r <= cfg_r.final_position_encoder_role != aec_pkg::SRC_NONE; // [R16]
      end
      else if (cfg_r.fb_sel == aec_pkg::FB_ROTOR)
      begin
        fb_pos_r <= role_elec(cfg_r.rotor_encoder_role, enc_count, size_r); // [R14]
        fb_valid_r <= cfg_r.rotor_encoder_role != aec_pkg::SRC_NONE;
      end
      else
      begin
        fb_pos_r <= '0;
        fb_valid_r <= 1'b0;
      end
      trip_r <= (cfg_r.safety_encoder_role != aec_pkg::SRC_NONE) &&
                (abs64(64'(saf_el - nominal_pos)) > lim_el); // [R15] [R16]
    end

  // Divider operands: sizes in 32.32 electrical periods, then conversions
  always_comb
  begin
    dneg = 1'b0;
    dval = '0;
    dden = size_r[0];
    dnum = '0;
    if (job_r == 3'h0)
    begin
      dnum = {32'({16'h0, cfg_r.axis_turns} * {16'h0, cfg_r.pole_pairs}), 32'h0}; // [R17] [R20]
      dden = {32'h0, cfg_r.axis_steps};
    end
    else if (job_r < aec_pkg::JOB_POS)
    begin
      dnum = {32'({16'h0, cfg_r.enc_turns[2'(job_r - 3'h1)]} * {16'h0, cfg_r.pole_pairs}), 32'h0}; // [R21]
      dden = {32'h0, cfg_r.enc_steps[2'(job_r - 3'h1)]};
    end
    else
    begin
      dval = (job_r == aec_pkg::JOB_POS) ? nominal_pos : (job_r == aec_pkg::JOB_MEAS) ? meas_el_r : pick_el_r;
      dneg = dval[63];
      dnum = 64'(abs64(dval) + {1'b0, dden[63:1]}); // [R25]
    end
  end

  // Shared restoring divider, one quotient bit a cycle
  assign trial = {rem_r, num_r[63]} - {1'b0, den_r};
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      dv_r <= aec_pkg::DV_LOAD;
      job_r <= '0;
      cnt_r <= '0;
      num_r <= '0;
      den_r <= '0;
      rem_r <= '0;
      neg_r <= 1'b0;
    end
    else
      unique case (dv_r)
        aec_pkg::DV_LOAD:
        begin
          num_r <= dnum;
          den_r <= dden;
          neg_r <= dneg;
          rem_r <= '0;
          cnt_r <= '0;
          dv_r <= aec_pkg::DV_RUN;
        end
        aec_pkg::DV_RUN:
          if (cnt_r == aec_pkg::DIV_STEPS)
          begin
            dv_r <= aec_pkg::DV_LOAD;
            job_r <= (job_r == aec_pkg::JOB_LAST) ? 3'h0 : 3'(job_r + 3'h1);
          end
          else
          begin
            cnt_r <= 7'(cnt_r + 7'h1);
            if (!trial[64])
            begin
              rem_r <= trial[63:0];
              num_r <= {num_r[62:0], 1'b1};
            end
            else
            begin
              rem_r <= {rem_r[62:0], num_r[63]};
              num_r <= {num_r[62:0], 1'b0};
            end
          end
      endcase

  // Results: step sizes kept at 64 bits, reports cut to 32
  assign sat = sat32(num_r, neg_r, den_r == 64'h0);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      size_r <= '0;
      conv_r <= '0;
      ovf_r <= '0;
    end
    else if (dv_r == aec_pkg::DV_RUN && cnt_r == aec_pkg::DIV_STEPS)
    begin
      if (job_r < aec_pkg::JOB_POS)
        size_r[job_r[1:0]] <= num_r; // [R19]
      else
      begin
        conv_r[2'(job_r - aec_pkg::JOB_POS)] <= sat[31:0]; // [R18] [R25]
        ovf_r[2'(job_r - aec_pkg::JOB_POS)] <= sat[32];
      end
    end

  // Read mux
  assign stat = '{ovf: ovf_r, boot_skip: skip_r, restored: restored_r, refused: refused_r,
                  warn: ot_s, trip: trip_r, follow: follow_err & fb_valid_r, ext: ext_s,
                  oc: oc_s, power: cfg_r.power, active: cfg_r.active};
  assign rslot = enc_slot(haddr[7:0]);
  always_comb
  begin
    rd_val = '0;
    unique case (haddr[7:0])
      aec_pkg::OFS_CTRL: rd_val = 32'({cfg_r.fb_sel, 1'b0, cfg_r.restore, cfg_r.power, cfg_r.active}); // [R3]
      aec_pkg::OFS_ROLE: rd_val = 32'({cfg_r.safety_encoder_role, cfg_r.rotor_encoder_role,
                                       cfg_r.final_position_encoder_role});
      aec_pkg::OFS_STEPS: rd_val = cfg_r.axis_steps;
      aec_pkg::OFS_TURNS: rd_val = {cfg_r.pole_pairs, cfg_r.axis_turns};
      aec_pkg::OFS_SAFE: rd_val = cfg_r.safe_limit;
      aec_pkg::OFS_STAT: rd_val = 32'(stat); // [R7]
      aec_pkg::OFS_PICK: rd_val = 32'(pick_r);
      aec_pkg::OFS_RAW: rd_val = (pick_r == 2'h3) ? 32'h0 : enc_count[pick_r]; // [R22]
      aec_pkg::OFS_ENCAX: rd_val = conv_r[2]; // [R22]
      aec_pkg::OFS_POS: rd_val = conv_r[0];
      aec_pkg::OFS_MEAS: rd_val = conv_r[1];
      aec_pkg::OFS_ADDR: rd_val = 32'(cfg_r.board_addr);
      default:
        if (rslot[3])
          rd_val = rslot[0] ? 32'(cfg_r.enc_turns[rslot[2:1]]) : cfg_r.enc_steps[rslot[2:1]];
    endcase
  end

  // Output flops
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      inhibit_r <= 1'b1;
      alarm_r <= 1'b0;
      warn_r <= 1'b0;
    end
    else
    begin
      inhibit_r <= !cfg_r.active; // [R1]
      alarm_r <= alarm_any;
      warn_r <= ot_s; // [R7]
    end

  assign hreadyout = hready_r;
  assign hrdata = hrdata_r;
  assign hresp = 1'b0;
  assign nv_wr = nv_wr_r;
  assign nv_data = nv_data_r;
  assign motor_power = cfg_r.power;
  assign axis_inhibit = inhibit_r;
  assign alarm = alarm_r;
  assign warning = warn_r;
  assign fb_valid = fb_valid_r;
  assign fb_pos = fb_pos_r;
  assign rotor_valid = rot_valid_r;
  assign rotor_pos = rot_pos_r;

  a_inhibit_off: assert property (@(posedge hclk) disable iff (!hresetn) !cfg_r.active |=> axis_inhibit) // [R1]
    else $error("inactive axis not inhibited");
  a_alarm_cut: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
    alarm_any && boot_r == aec_pkg::BT_RUN |=> !motor_power)
    else $error("alarm left power on");
  a_alarm_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
    alarm_any && !motor_power ##1 alarm_any |-> !motor_power)
    else $error("power granted during alarm");
  a_warn_grant: assert property (@(posedge hclk) disable iff (!hresetn) pwr_req && pwr_ok |=> motor_power) // [R7]
    else $error("valid power request not granted");
  a_move_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
    boot_r == aec_pkg::BT_RUN && moved |=> !cfg_r.active && cfg_r.board_addr == $past(addr_s))
    else $error("moved board kept activation");
  a_boot_skip: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
    boot_r == aec_pkg::BT_CHECK && alarm_any |=> !motor_power && !restored_r)
    else $error("restore ran during alarm");
  a_safety_off: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    cfg_r.safety_encoder_role == aec_pkg::SRC_NONE |=> !trip_r)
    else $error("trip without safety encoder");
  a_sat_value: assert property (@(posedge hclk) disable iff (!hresetn) // [R25]
    $rose(ovf_r[0]) |-> conv_r[0] == aec_pkg::SAT_POS || conv_r[0] == aec_pkg::SAT_NEG)
    else $error("overflow without saturation");
  a_meas_nom: assert property (@(posedge hclk) disable iff (!hresetn) // [R24]
    cfg_r.final_position_encoder_role == aec_pkg::SRC_NONE && cfg_r.rotor_encoder_role == aec_pkg::SRC_NONE
    |=> meas_el_r == $past(nominal_pos))
    else $error("measured not nominal");
  a_fb_none: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    cfg_r.fb_sel == aec_pkg::FB_FINAL && cfg_r.final_position_encoder_role == aec_pkg::SRC_NONE
    |=> !fb_valid)
    else $error("feedback valid without encoder");
endmodule : aec_axis_cfg
`default_nettype wire

//--- pkg/aec_pkg.sv
// Shared constants and types for the axis enable and encoder configuration block
package aec_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ROLE = 8'h04;
  localparam logic [7:0] OFS_STEPS = 8'h08;
  localparam logic [7:0] OFS_TURNS = 8'h0c;
  localparam logic [7:0] OFS_ENC_LO = 8'h10;
  localparam logic [7:0] OFS_ENC_HI = 8'h24;
  localparam logic [7:0] OFS_SAFE = 8'h28;
  localparam logic [7:0] OFS_STAT = 8'h2c;
  localparam logic [7:0] OFS_PICK = 8'h30;
  localparam logic [7:0] OFS_RAW = 8'h34;
  localparam logic [7:0] OFS_ENCAX = 8'h38;
  localparam logic [7:0] OFS_POS = 8'h3c;
  localparam logic [7:0] OFS_MEAS = 8'h40;
  localparam logic [7:0] OFS_ADDR = 8'h44;
  // Field positions
  localparam int CTRL_ACT = 0;
  localparam int CTRL_PWR = 1;
  localparam int CTRL_RST = 2;
  localparam int CTRL_FB = 4;
  localparam int ROLE_FIN = 0;
  localparam int ROLE_ROT = 2;
  localparam int ROLE_SAF = 4;
  localparam int STAT_REFUSED = 7;
  localparam int TURNS_PP = 16;
  // Bus and arithmetic constants
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [31:0] SAT_POS = 32'h7fffffff;
  localparam logic [31:0] SAT_NEG = 32'h80000000;
  localparam logic [6:0] DIV_STEPS = 7'h40;
  localparam logic [2:0] JOB_POS = 3'h4;
  localparam logic [2:0] JOB_MEAS = 3'h5;
  localparam logic [2:0] JOB_LAST = 3'h6;

  typedef enum logic [1:0] {SRC_NONE, SRC_REAR_INC, SRC_FRONT_INC, SRC_REAR_ABS} aec_src_e;
  typedef enum logic [1:0] {FB_NONE, FB_FINAL, FB_ROTOR, FB_RSVD} aec_fb_e;
  typedef enum logic [1:0] {BT_LOAD, BT_SYNC, BT_CHECK, BT_RUN} aec_boot_e;
  typedef enum logic {DV_LOAD, DV_RUN} aec_div_e;
  typedef logic [2:0][31:0] aec_cnt_t;

  typedef struct packed {
    logic [7:0] board_addr;
    logic [31:0] safe_limit;
    logic [2:0][15:0] enc_turns;
    logic [2:0][31:0] enc_steps;
    logic [15:0] pole_pairs;
    logic [15:0] axis_turns;
    logic [31:0] axis_steps;
    aec_src_e safety_encoder_role;
    aec_src_e rotor_encoder_role;
    aec_src_e final_position_encoder_role;
    aec_fb_e fb_sel;
    logic restore;
    logic power;
    logic active;
  } aec_cfg_s;

  typedef struct packed {
    logic [2:0] ovf;
    logic boot_skip;
    logic restored;
    logic refused;
    logic warn;
    logic trip;
    logic follow;
    logic ext;
    logic oc;
    logic power;
    logic active;
  } aec_stat_s;
endpackage : aec_pkg

//--- tb/aec_far_model.sv
// Far-side model: non-volatile store and encoder counts
`timescale 1ns/1ps
`default_nettype none
module aec_far_model (
  // Clock
  input wire logic hclk,
  // Store port
  input wire logic nv_wr,
  input wire aec_pkg::aec_cfg_s nv_data,
  output var logic nv_valid,
  output var aec_pkg::aec_cfg_s nv_cfg,
  // Encoders
  output var aec_pkg::aec_cnt_t enc_count
);
  initial
  begin
    nv_valid = 1'b1;
    nv_cfg = '0;
    nv_cfg.board_addr = 8'h15;
    enc_count = '0;
    enc_count[0] = 32'h00000123;
    // Image outlives resets, as flash would
    forever
    begin
      @(posedge hclk);
      if (nv_wr)
        nv_cfg <= nv_data;
    end
  end
endmodule : aec_far_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the axis configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [31:0] ctrl; logic oc; logic ot; logic pwr;} aec_row_s;
  logic hclk, hresetn, hwrite, hreadyout, hresp, nv_wr, nv_valid, oc, ext, ot, follow;
  logic motor_power, axis_inhibit, alarm, warning, fbv, rv;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [7:0] slot;
  aec_pkg::aec_cfg_s nv_cfg, nv_data;
  aec_pkg::aec_cnt_t enc_count;
  int fails, total_checks, cycles;
  // Inactive refusal, activation, warning, alarm refusal, grant, power off
  aec_row_s rows [6] = '{'{32'h2, 1'b0, 1'b0, 1'b0}, '{32'h1, 1'b0, 1'b0, 1'b0},
    '{32'h3, 1'b0, 1'b1, 1'b1}, '{32'h3, 1'b1, 1'b0, 1'b0}, '{32'h3, 1'b0, 1'b0, 1'b1},
    '{32'h1, 1'b0, 1'b0, 1'b0}};
  aec_axis_cfg dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(aec_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .slot_addr_pin(slot),
    .overcurrent_pin(oc), .ext_alarm_pin(ext), .overtemp_pin(ot), .follow_err(follow),
    .nominal_pos(64'h0), .enc_count(enc_count), .nv_valid(nv_valid), .nv_cfg(nv_cfg),
    .nv_wr(nv_wr), .nv_data(nv_data), .motor_power(motor_power), .axis_inhibit(axis_inhibit),
    .alarm(alarm), .warning(warning), .fb_valid(fbv), .fb_pos(), .rotor_valid(rv), .rotor_pos());
  aec_far_model far (.hclk(hclk), .nv_wr(nv_wr), .nv_data(nv_data), .nv_valid(nv_valid),
    .nv_cfg(nv_cfg), .enc_count(enc_count));
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Single AHB transfer; waits on hready at both phases
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    check("hresp", hresp, 32'h0);
  endtask : bus
  task automatic reboot();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask : reboot
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  // Ceiling well above the roughly 150 cycles the run needs
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      test_done();
    end
  end
  initial
  begin
    {hresetn, hwrite, oc, ext, ot, follow, haddr, hwdata, htrans} = '0;
    slot = 8'h15;
    repeat (3) @(posedge hclk);
    check("inhibit_rst", axis_inhibit, 32'h1);
    check("power_rst", motor_power, 32'h0);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    for (int i = 0; i < 6; i++)
    begin
      oc <= rows[i].oc;
      ot <= rows[i].ot;
      repeat (6) @(posedge hclk);
      bus(aec_pkg::OFS_CTRL, 1'b1, rows[i].ctrl);
      repeat (3) @(posedge hclk);
      check("power", motor_power, rows[i].pwr);
      check("warning", warning, rows[i].ot);
    end
    bus(aec_pkg::OFS_STAT, 1'b0, 32'h0);
    check("status", q[9:0], 32'h81);
    bus(aec_pkg::OFS_STAT, 1'b1, 32'h80);
    bus(aec_pkg::OFS_STAT, 1'b0, 32'h0);
    check("refused_clr", q[7], 32'h0);
    bus(aec_pkg::OFS_TURNS, 1'b1, 32'h00320001);
    bus(aec_pkg::OFS_TURNS, 1'b0, 32'h0);
    check("turns", q, 32'h00320001);
    bus(aec_pkg::OFS_RAW, 1'b0, 32'h0);
    check("raw", q, 32'h123);
    bus(aec_pkg::OFS_CTRL, 1'b1, 32'h3);
    ext <= 1'b1;
    repeat (6) @(posedge hclk);
    check("ext_alarm", {alarm, motor_power}, 32'h2);
    ext <= 1'b0;
    bus(aec_pkg::OFS_ROLE, 1'b1, 32'h1);
    bus(aec_pkg::OFS_CTRL, 1'b1, 32'h13);
    follow <= 1'b1;
    repeat (4) @(posedge hclk);
    check("follow_alarm", motor_power, 32'h0);
    check("fb_valid", {fbv, rv}, 32'h2);
    follow <= 1'b0;
    bus(aec_pkg::OFS_CTRL, 1'b1, 32'h7);
    repeat (4) @(posedge hclk);
    reboot();
    check("restore", motor_power, 32'h1);
    oc <= 1'b1;
    reboot();
    check("boot_skip", motor_power, 32'h0);
    oc <= 1'b0;
    bus(8'h48, 1'b0, 32'h0);
    check("unmapped", q, 32'h0);
    bus(aec_pkg::OFS_CTRL, 1'b1, 32'h3);
    slot <= 8'h16;
    repeat (8) @(posedge hclk);
    bus(aec_pkg::OFS_CTRL, 1'b0, 32'h0);
    check("moved_active", {q[0], axis_inhibit, motor_power}, 32'h2);
    test_done();
  end
endmodule : testbench
`default_nettype wire
